//--- hdl/bore_map.svh
// bit-operation and relative-branch constants: opcodes, fields, widths
// assumes 14-bit instruction words and a 15-bit program counter
`ifndef BORE_MAP_SVH
`define BORE_MAP_SVH

`define BORE_INSN_W       14
`define BORE_PC_W         15
`define BORE_ADDR_W       7
`define BORE_DATA_W       8
`define BORE_BIT_W        3
// opcode fields
`define BORE_BITOP_HI     13
`define BORE_BITOP_LO     10
`define BORE_OP_CLEAR     4'h4
`define BORE_OP_SET       4'h5
`define BORE_OP_SKIP_ZERO 4'h6
`define BORE_OP_SKIP_ONE  4'h7
`define BORE_BRA_HI       13
`define BORE_BRA_LO       9
`define BORE_OP_BRA       5'h19
`define BORE_OP_BRW       14'h000b
`define BORE_NOP          14'h0000
// operand fields
`define BORE_FILE_HI      6
`define BORE_BITNO_HI     9
`define BORE_BITNO_LO     7
`define BORE_K_HI         8
`define BORE_K_W          9
// reset values
`define BORE_PC_RST       15'h0000

`endif

//--- hdl/bore_pkg.sv
// types for the bit-operation and relative-branch executor
// assumes bore_map.svh has been seen by the includer
package bore_pkg;
    typedef enum logic [2:0] {
        BORE_OP_NONE,
        BORE_OP_BCLR,
        BORE_OP_BSET,
        BORE_OP_TSZ,
        BORE_OP_TSO,
        BORE_OP_BRL,
        BORE_OP_BRWK
    } bore_op_e;
endpackage

//--- hdl/bore_decode.sv
// instruction classifier for the executor
// assumes a full 14-bit word from the fetch stage
`timescale 1ns/1ns
`include "bore_map.svh"

module bore_decode
    import bore_pkg::*;
(
    // instruction in
    input  wire logic [`BORE_INSN_W-1:0] insn,
    // class out
    output bore_op_e                     op
);
    // opcode match; brw is a whole-word code so it is tested first
    always_comb begin
        op = BORE_OP_NONE;
        if (insn == `BORE_OP_BRW) begin
            op = BORE_OP_BRWK;
        end else if (insn[`BORE_BRA_HI:`BORE_BRA_LO] == `BORE_OP_BRA) begin
            op = BORE_OP_BRL;
        end else begin
            unique case (insn[`BORE_BITOP_HI:`BORE_BITOP_LO])
                `BORE_OP_CLEAR:     op = BORE_OP_BCLR;
                `BORE_OP_SET:       op = BORE_OP_BSET;
                `BORE_OP_SKIP_ZERO: op = BORE_OP_TSZ;
                `BORE_OP_SKIP_ONE:  op = BORE_OP_TSO;
                default:            op = BORE_OP_NONE;
            endcase
        end
    end
endmodule

//--- hdl/bore_exec.sv
// executor for bit set/clear, bit test-and-skip and relative branches
// assumes data read of the addressed file register arrives in the same cycle
`timescale 1ns/1ns
`include "bore_map.svh"

module bore_exec
    import bore_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // instruction issue
    input  wire logic                     insn_valid,
    input  wire logic [`BORE_INSN_W-1:0]  insn,
    // operand sources
    input  wire logic [`BORE_DATA_W-1:0]  file_rdata,
    input  wire logic [`BORE_DATA_W-1:0]  working_reg,
    // file register access
    output logic [`BORE_ADDR_W-1:0]       file_addr_ff,
    output logic [`BORE_DATA_W-1:0]       file_wdata_ff,
    output logic                          file_we_ff,
    // program counter and sequencing
    output logic [`BORE_PC_W-1:0]         program_counter_ff,
    output logic                          flush_ff,
    output logic                          busy_ff,
    output logic                          status_we_ff
);
    bore_op_e                    op;
    logic                        second_ff;
    logic                        take;
    logic                        tested_bit;
    logic [`BORE_BIT_W-1:0]      bitno;
    logic [`BORE_ADDR_W-1:0]     faddr;
    logic [`BORE_DATA_W-1:0]     mask;
    logic [`BORE_PC_W-1:0]       pc_inc;
    logic [`BORE_PC_W-1:0]       k_ext;
    logic [`BORE_PC_W-1:0]       w_ext;
    logic [`BORE_PC_W-1:0]       nxt_pc;
    logic                        nxt_second;
    logic                        skip_ff;
    logic                        nxt_skip;
    logic                        skip_step;
    logic                        is_bit_write;
    logic [`BORE_DATA_W-1:0]     lane_hit;
    logic [`BORE_DATA_W-1:0]     set_val;
    logic [`BORE_DATA_W-1:0]     clr_val;
    genvar                       gi;

    bore_decode u_decode (
        .insn (insn),
        .op   (op)
    );

    // one-hot bit mask, shared by set, clear and test
    function automatic logic [`BORE_DATA_W-1:0] bit_mask(input logic [`BORE_BIT_W-1:0] b);
        bit_mask = `BORE_DATA_W'(1) << b;
    endfunction

    // operand fields
    assign bitno      = insn[`BORE_BITNO_HI:`BORE_BITNO_LO];
    assign faddr      = insn[`BORE_FILE_HI:0];
    assign mask       = bit_mask(bitno);
    assign tested_bit = |lane_hit;
    // the counter has not yet advanced past this word when it executes
    assign pc_inc     = program_counter_ff + `BORE_PC_W'(1);
    // sign-extend k to counter width; wraps modulo the counter as the core does
    assign k_ext      = {{(`BORE_PC_W-`BORE_K_W){insn[`BORE_K_HI]}}, insn[`BORE_K_HI:0]};
    assign w_ext      = {{(`BORE_PC_W-`BORE_DATA_W){1'b0}}, working_reg};
    // an accepted word is ignored during the second cycle of a two-cycle op
    assign take       = insn_valid && !second_ff;
    // second cycle of a taken skip: the word on insn is the one being dropped
    assign skip_step  = second_ff && skip_ff;

    // a write-back happens only for an accepted set or clear
    assign is_bit_write = take && (op == BORE_OP_BCLR || op == BORE_OP_BSET);

    // per-bit work on the read data; one lane per data bit
    generate
        for (gi = 0; gi < `BORE_DATA_W; gi++) begin : g_lane
            // lane picked by the bit number feeds the skip test
            assign lane_hit[gi] = file_rdata[gi] & mask[gi];
            assign clr_val[gi]  = file_rdata[gi] & ~mask[gi];
            assign set_val[gi]  = file_rdata[gi] | mask[gi];
        end
    endgenerate

    // next counter and two-cycle decision
    always_comb begin
        nxt_pc     = program_counter_ff;
        nxt_second = 1'b0;
        nxt_skip   = 1'b0;
        if (take) begin
            nxt_pc = pc_inc;
            unique case (op)
                BORE_OP_BRL: begin
                    nxt_pc     = pc_inc + k_ext;
                    nxt_second = 1'b1;
                end
                BORE_OP_BRWK: begin
                    nxt_pc     = pc_inc + w_ext;
                    nxt_second = 1'b1;
                end
                BORE_OP_TSZ: begin
                    nxt_second = !tested_bit;
                    nxt_skip   = !tested_bit;
                end
                BORE_OP_TSO: begin
                    nxt_second = tested_bit;
                    nxt_skip   = tested_bit;
                end
                BORE_OP_BCLR, BORE_OP_BSET, BORE_OP_NONE: nxt_second = 1'b0;
            endcase
        end else if (skip_step) begin
            // dropped word stepped over; else the core would fetch it again
            nxt_pc = pc_inc;
        end
    end

    // program counter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            program_counter_ff <= `BORE_PC_RST;
        end else begin
            program_counter_ff <= nxt_pc;
        end
    end

    // second-cycle tracking; during it the fetched word is discarded as a no-op
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            second_ff <= 1'b0;
        end else begin
            second_ff <= nxt_second;
        end
    end

    // remembers that the second cycle belongs to a skip, not a branch
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            skip_ff <= 1'b0;
        end else begin
            skip_ff <= nxt_skip;
        end
    end

    // flush strobe to the fetch stage; a copy so the output stays a plain flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flush_ff <= 1'b0;
        end else begin
            flush_ff <= nxt_second;
        end
    end

    // busy mirrors flush for cores that stall on it instead
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_second;
        end
    end

    // write strobe, one cycle per accepted set or clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            file_we_ff <= 1'b0;
        end else begin
            file_we_ff <= is_bit_write;
        end
    end

    // write address; held between writes so the core can reuse it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            file_addr_ff <= '0;
        end else if (is_bit_write) begin
            file_addr_ff <= faddr;
        end
    end

    // write data: read-modify-write of the same-cycle read, so other bits survive
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            file_wdata_ff <= '0;
        end else if (take && op == BORE_OP_BCLR) begin
            file_wdata_ff <= clr_val;
        end else if (take && op == BORE_OP_BSET) begin
            file_wdata_ff <= set_val;
        end
    end

    // none of these ops touch status; the strobe exists so the core can see it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_we_ff <= 1'b0;
        end else begin
            status_we_ff <= 1'b0;
        end
    end
endmodule

//--- tb/bore_exec_checker.sv
// port checker for bore_exec: bit writes, skips, branch targets
// assumes one clock domain; bound onto every bore_exec instance
`timescale 1ns/1ns
module bore_exec_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        insn_valid,
    input wire logic [13:0] insn,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  working_reg,
    input wire logic [6:0]  file_addr_ff,
    input wire logic [7:0]  file_wdata_ff,
    input wire logic        file_we_ff,
    input wire logic [14:0] program_counter_ff,
    input wire logic        flush_ff,
    input wire logic        busy_ff,
    input wire logic        status_we_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // words issued during a flush are dropped, so only taken ones count
    wire        take    = insn_valid && !flush_ff;
    wire        tbit    = file_rdata[insn[9:7]];
    wire [7:0]  clr_val = file_rdata & ~(8'h01 << insn[9:7]);
    wire [7:0]  set_val = file_rdata | (8'h01 << insn[9:7]);
    wire [14:0] pc_inc  = program_counter_ff + 15'h0001;
    wire [14:0] lit_pc  = pc_inc + {{6{insn[8]}}, insn[8:0]};
    wire [14:0] w_pc    = pc_inc + {7'h00, working_reg};
    // marks a flush cycle that drops the word after a skip
    logic       skip_seen;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            skip_seen <= 1'b0;
        end else begin
            skip_seen <= take && insn[13:11] == 3'b011;
        end
    end
    clr_write_a: assert property (take && insn[13:10] == 4'h4 |=> file_we_ff &&
        file_addr_ff == $past(insn[6:0]) && file_wdata_ff == $past(clr_val))
        else $error("bit clear write wrong");
    set_write_a: assert property (take && insn[13:10] == 4'h5 |=> file_we_ff &&
        file_addr_ff == $past(insn[6:0]) && file_wdata_ff == $past(set_val))
        else $error("bit set write wrong");
    skip_zero_a: assert property (take && insn[13:10] == 4'h6 |=>
        flush_ff == !$past(tbit)) else $error("skip if zero wrong");
    skip_one_a: assert property (take && insn[13:10] == 4'h7 |=> flush_ff == $past(tbit))
        else $error("skip if one wrong");
    lit_branch_a: assert property (take && insn[13:9] == 5'h19 |=>
        flush_ff ##0 program_counter_ff == $past(lit_pc)) else $error("literal branch wrong");
    w_branch_a: assert property (take && insn == 14'h000b |=>
        flush_ff && program_counter_ff == $past(w_pc)) else $error("w branch wrong");
    flush_short_a: assert property (flush_ff |=> !flush_ff &&
        program_counter_ff == $past(program_counter_ff + {14'h0000, skip_seen}))
        else $error("flush not single cycle");
    busy_match_a: assert property (busy_ff == flush_ff)
        else $error("busy differs from flush");
    flag_quiet_a: assert property (take ##1 1'b1 [*2] |-> !status_we_ff)
        else $error("status written");
    one_cycle_a: assert property (take && insn[13:11] == 3'b010 |=> !flush_ff &&
        program_counter_ff == $past(pc_inc)) else $error("bit op not one cycle");
endmodule
bind bore_exec bore_exec_checker chk_i (.clk(clk), .rst_b(rst_b), .insn_valid(insn_valid),
    .insn(insn), .file_rdata(file_rdata), .working_reg(working_reg),
    .file_addr_ff(file_addr_ff), .file_wdata_ff(file_wdata_ff), .file_we_ff(file_we_ff),
    .program_counter_ff(program_counter_ff), .flush_ff(flush_ff), .busy_ff(busy_ff),
    .status_we_ff(status_we_ff));

//--- tb/tb_top.sv
// bench for bore_exec: bit set/clear, test-and-skip, relative branches
// assumes a 125 MHz clock and synchronous active-low reset
`timescale 1ns/1ns
`include "bore_map.svh"
module tb_top;
    logic        clk, rst_b, insn_valid, file_we_ff, flush_ff, busy_ff, status_we_ff;
    logic [13:0] insn;
    logic [7:0]  file_rdata, working_reg, file_wdata_ff;
    logic [6:0]  file_addr_ff;
    logic [14:0] program_counter_ff, p;
    int          fails, samples_checked;
    bore_exec uut (.clk(clk), .rst_b(rst_b), .insn_valid(insn_valid), .insn(insn),
        .file_rdata(file_rdata), .working_reg(working_reg), .file_addr_ff(file_addr_ff),
        .file_wdata_ff(file_wdata_ff), .file_we_ff(file_we_ff), .busy_ff(busy_ff),
        .program_counter_ff(program_counter_ff), .flush_ff(flush_ff),
        .status_we_ff(status_we_ff));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // issue one word; results are settled by the falling edge after it is taken
    task automatic go(input logic [13:0] w, input logic [7:0] r, wr);
        @(negedge clk) p = program_counter_ff;
        @(posedge clk);
        {insn_valid, insn, file_rdata, working_reg} <= {1'b1, w, r, wr};
        @(posedge clk);
        insn_valid <= 1'b0;
        @(negedge clk);
    endtask
    // every bit position, register 127 for clear and 42 for set
    task automatic t_bitops;
        for (int b = 0; b < 8; b++) begin
            go({`BORE_OP_CLEAR, b[2:0], 7'h7f}, 8'hff, 8'h00);
            chk("clr data", {1'b1, 7'h7f, ~(8'h01 << b)},
                {file_we_ff, file_addr_ff, file_wdata_ff});
            chk("clr pc", {1'b0, p + 15'h0001}, {flush_ff, program_counter_ff});
            go({`BORE_OP_SET, b[2:0], 7'h2a}, 8'h00, 8'h00);
            chk("set data", {1'b1, 7'h2a, 8'h01 << b},
                {file_we_ff, file_addr_ff, file_wdata_ff});
            chk("set pc", {1'b0, p + 15'h0001}, {flush_ff, program_counter_ff});
        end
    endtask
    // bit 5 tested; a taken skip steps the counter past the dropped word
    task automatic t_skip(input logic [3:0] op, input logic [7:0] r, input logic fl);
        go({op, 3'h5, 7'h10}, r, 8'h00);
        chk("skip flush", {14'h0000, fl, fl}, {14'h0000, flush_ff, busy_ff});
        chk("skip pc", {1'b0, p + 15'h0001}, {1'b0, program_counter_ff});
        @(negedge clk);
        chk("skip end pc", {1'b0, p + 15'h0001 + 15'(fl)},
            {flush_ff, program_counter_ff});
    endtask
    // target check, then the flush must end after one cycle
    task automatic t_br(input logic [13:0] w, input logic [7:0] wr, input logic [14:0] off);
        go(w, 8'h00, wr);
        chk("br pc", {1'b1, p + 15'h0001 + off}, {flush_ff, program_counter_ff});
        chk("br status", 16'h0000, {15'h0000, status_we_ff});
        @(negedge clk);
        chk("br flush end", {1'b0, p + 15'h0001 + off},
            {flush_ff, program_counter_ff});
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {rst_b, insn_valid, insn, file_rdata, working_reg} = '0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_bitops();
        t_skip(`BORE_OP_SKIP_ZERO, 8'hdf, 1'b1);
        t_skip(`BORE_OP_SKIP_ZERO, 8'h20, 1'b0);
        t_skip(`BORE_OP_SKIP_ONE, 8'h20, 1'b1);
        t_skip(`BORE_OP_SKIP_ONE, 8'hdf, 1'b0);
        t_br({`BORE_OP_BRA, 9'h100}, 8'h00, 15'h7f00);
        t_br({`BORE_OP_BRA, 9'h0ff}, 8'h00, 15'h00ff);
        t_br(`BORE_OP_BRW, 8'hff, 15'h00ff);
        t_br(`BORE_OP_BRW, 8'h80, 15'h0080);
        tally_and_finish();
    end
    // the sequence needs well under 200 cycles
    initial begin
        #20000;
        fails++;
        tally_and_finish();
    end
endmodule
